// ---- rtl/acc_top.v ----
// Digital control around the analog comparator: APB registers, hysteresis latch, interrupt and pin output.
// Assumes an APB master on clock, and an analog front end that gives two raw flags: positive above
// negative by the hysteresis, and negative above positive by the hysteresis.
`timescale 1ns/100ps
`include "acc_map.vh"

module acc_top
(
  clock,
  nrst,
  ce,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  prdata,
  pready,
  pslverr,
  raw_above,
  raw_below,
  positive_input_select,
  negative_input_select,
  reference_enable,
  reference_level,
  comparator_power_down,
  comparator_out_pin,
  comparator_out_pin_oe,
  interrupt_request
);

input wire clock;
input wire nrst;
input wire ce;
input wire psel;
input wire penable;
input wire pwrite;
input wire [11:0] paddr;
input wire [31:0] pwdata;
output wire [31:0] prdata;
output wire pready;
output wire pslverr;
input wire raw_above;
input wire raw_below;
output wire positive_input_select;
output wire negative_input_select;
output wire reference_enable;
output wire [3:0] reference_level;
output wire comparator_power_down;
output wire comparator_out_pin;
output wire comparator_out_pin_oe;
output wire interrupt_request;

// ----------------------------------------------------------------------
// Register select codes
// ----------------------------------------------------------------------
localparam [2:0] SEL_NONE = 3'h0;
localparam [2:0] SEL_CTRL = 3'h1;
localparam [2:0] SEL_PWR = 3'h2;
localparam [2:0] SEL_STAT = 3'h3;
localparam [2:0] SEL_MASK = 3'h4;

// Address decode shared by the read mux and the write strobes.
function [2:0] acc_decode;
  input [11:0] addr;
  begin
    case (addr)
      `ACC_OFS_CTRL: acc_decode = SEL_CTRL;
      `ACC_OFS_PWR: acc_decode = SEL_PWR;
      `ACC_OFS_STAT: acc_decode = SEL_STAT;
      `ACC_OFS_MASK: acc_decode = SEL_MASK;
      default: acc_decode = SEL_NONE;
    endcase
  end
endfunction

// ----------------------------------------------------------------------
// State
// ----------------------------------------------------------------------
reg [7:0] ctrl_ff;
reg [1:0] pwr_ff;
reg [`ACC_EVT_W-1:0] status_ff;
reg [`ACC_EVT_W-1:0] mask_ff;
reg [31:0] prdata_ff;
reg pready_ff;
reg pslverr_ff;
reg result_ff;
reg ref_en_ff;
reg pin_ff;
reg pin_oe_ff;
reg irq_ff;
reg [31:0] rd_value;
reg nxt_result;
reg [`ACC_EVT_W-1:0] nxt_status;
wire [1:0] flags_sync;
wire [2:0] sel;
wire access;
wire done;
wire wr_done;
wire [3:0] lvl;

// Raw analog flags are asynchronous to the clock.
acc_sync #(.WIDTH(2)) u_sync
(
  .clock(clock),
  .nrst(nrst),
  .ce(ce),
  .async_in({raw_below, raw_above}),
  .sync_out(flags_sync)
);

assign sel = acc_decode(paddr);
assign access = psel & penable;
assign done = access & pready_ff;
assign wr_done = done & pwrite;
assign lvl = ctrl_ff[`ACC_CTRL_LVL_MSB:`ACC_CTRL_LVL_LSB];

// ----------------------------------------------------------------------
// Read mux
// ----------------------------------------------------------------------
// readback value
always @*
begin
  rd_value = 32'h0000_0000;
  case (sel)
    SEL_CTRL: rd_value[7:0] = ctrl_ff;
    SEL_PWR: rd_value[1:0] = pwr_ff;
    SEL_STAT:
    begin
      rd_value[`ACC_EVT_W-1:0] = status_ff;
      rd_value[`ACC_STAT_LEVEL_BIT] = result_ff;
    end
    SEL_MASK: rd_value[`ACC_EVT_W-1:0] = mask_ff;
    default: rd_value = 32'h0000_0000;
  endcase
end

// ----------------------------------------------------------------------
// APB slave: one wait state, then pready for one cycle
// ----------------------------------------------------------------------
// Read data is captured when pready rises, so it is stable at the completing edge.
always @(posedge clock)
begin
  if (!nrst)
  begin
    pready_ff <= 1'b0;
    pslverr_ff <= 1'b0;
    prdata_ff <= 32'h0000_0000;
  end
  else if (ce)
  begin
    if (done)
    begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end
    else if (access)
    begin
      pready_ff <= 1'b1;
      pslverr_ff <= (sel == SEL_NONE);
      prdata_ff <= pwrite ? 32'h0000_0000 : rd_value;
    end
  end
end

// ----------------------------------------------------------------------
// Configuration registers
// ----------------------------------------------------------------------
// control, power and mask register reset and write
always @(posedge clock)
begin
  if (!nrst)
  begin
    ctrl_ff <= `ACC_CTRL_RST;
    pwr_ff <= `ACC_PWR_RST;
    mask_ff <= `ACC_MASK_RST;
  end
  else if (ce && wr_done)
  begin
    if (sel == SEL_CTRL)
      ctrl_ff <= pwdata[7:0];
    if (sel == SEL_PWR)
      pwr_ff <= pwdata[1:0];
    if (sel == SEL_MASK)
      mask_ff <= pwdata[`ACC_EVT_W-1:0];
  end
end

// ----------------------------------------------------------------------
// Hysteresis latch and events
// ----------------------------------------------------------------------
// set, clear or hold
always @*
begin
  nxt_result = result_ff;
  if (!pwr_ff[`ACC_PWR_DOWN_BIT])
  begin
    if (flags_sync[0] && !flags_sync[1])
      nxt_result = 1'b1;
    else if (flags_sync[1] && !flags_sync[0])
      nxt_result = 1'b0;
  end
end

// change events, set wins over read clear
// Only bits that were returned by the read are cleared, so an event landing
// between capture and completion survives.
always @*
begin
  nxt_status = status_ff;
  if (done && !pwrite && sel == SEL_STAT)
    nxt_status = status_ff & ~prdata_ff[`ACC_EVT_W-1:0];
  if (nxt_result != result_ff)
  begin
    nxt_status[`ACC_EVT_CHG_BIT] = 1'b1;
    nxt_status[`ACC_EVT_RISE_BIT] = nxt_status[`ACC_EVT_RISE_BIT] | nxt_result;
    nxt_status[`ACC_EVT_FALL_BIT] = nxt_status[`ACC_EVT_FALL_BIT] | ~nxt_result;
  end
end

always @(posedge clock)
begin
  if (!nrst)
  begin
    result_ff <= 1'b0;
    status_ff <= {`ACC_EVT_W{1'b0}};
    irq_ff <= 1'b0;
    pin_ff <= 1'b0;
    pin_oe_ff <= 1'b0;
  end
  else if (ce)
  begin
    result_ff <= nxt_result;
    status_ff <= nxt_status;
    irq_ff <= |(nxt_status & mask_ff);
    pin_ff <= nxt_result & pwr_ff[`ACC_PWR_PIN_BIT];
    pin_oe_ff <= pwr_ff[`ACC_PWR_PIN_BIT];
  end
end

// ----------------------------------------------------------------------
// Analog control outputs
// ----------------------------------------------------------------------
// reference enable
// reserved levels keep the reference off rather than drive an undefined tap.
always @(posedge clock)
begin
  if (!nrst)
    ref_en_ff <= 1'b0;
  else if (ce)
    ref_en_ff <= ctrl_ff[`ACC_CTRL_NSEL_BIT] & (lvl <= `ACC_LVL_MAX) & ~pwr_ff[`ACC_PWR_DOWN_BIT];
end

assign positive_input_select = ctrl_ff[`ACC_CTRL_PSEL_BIT];
assign negative_input_select = ctrl_ff[`ACC_CTRL_NSEL_BIT];
assign reference_level = lvl;
assign reference_enable = ref_en_ff;
assign comparator_power_down = pwr_ff[`ACC_PWR_DOWN_BIT];
assign comparator_out_pin = pin_ff;
assign comparator_out_pin_oe = pin_oe_ff;
assign interrupt_request = irq_ff;
assign prdata = prdata_ff;
assign pready = pready_ff;
assign pslverr = pslverr_ff;

endmodule // acc_top

// ---- rtl/acc_map.vh ----
// Register map, field positions, reset values and event bits of the comparator control block.
// Assumes an APB master on the system clock and an analog comparator with two raw threshold flags.
//
// Summary of operation
// - The result goes high when the positive input leads by more than the hysteresis, low when the negative leads, otherwise it holds.
// - The result raises an interrupt request and can be driven out to an external pin.
// - A power control bit puts the comparator into a powered-down state to save supply current.
// - An 8-bit read/write control register sits at F90H and resets to 00010100.
// - Control bit 7 picks the positive input, 0 for the pin and 1 for the temperature sensor.
// - Control bit 6 picks the negative input, 0 for the pin with the reference off and 1 for the internal reference.
// - Control bits 5 to 2 set the reference in 0.2 V steps, default 0101, with codes 1010 to 1111 reserved.
`ifndef ACC_MAP_VH
`define ACC_MAP_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define ACC_OFS_CTRL 12'hF90
`define ACC_OFS_PWR 12'hF94
`define ACC_OFS_STAT 12'hF98
`define ACC_OFS_MASK 12'hF9C

// ----------------------------------------------------------------------
// Control register fields and reset value
// ----------------------------------------------------------------------
`define ACC_CTRL_RST 8'h14
`define ACC_CTRL_PSEL_BIT 7
`define ACC_CTRL_NSEL_BIT 6
`define ACC_CTRL_LVL_MSB 5
`define ACC_CTRL_LVL_LSB 2
`define ACC_LVL_MAX 4'h9

// ----------------------------------------------------------------------
// Power register fields and reset value
// ----------------------------------------------------------------------
`define ACC_PWR_RST 2'h0
`define ACC_PWR_DOWN_BIT 0
`define ACC_PWR_PIN_BIT 1

// ----------------------------------------------------------------------
// Status and mask layout
// ----------------------------------------------------------------------
`define ACC_EVT_W 3
`define ACC_EVT_CHG_BIT 0
`define ACC_EVT_RISE_BIT 1
`define ACC_EVT_FALL_BIT 2
`define ACC_STAT_LEVEL_BIT 7
`define ACC_MASK_RST 3'h0

`endif

// ---- rtl/acc_sync.v ----
// Two-stage synchroniser for levels arriving from outside the clock domain.
// Assumes the inputs are quasi-static levels; the first stage feeds only the second.
`timescale 1ns/100ps

module acc_sync
#(
  parameter WIDTH = 2
)
(
  input wire clock,
  input wire nrst,
  input wire ce,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

reg [WIDTH-1:0] meta_ff;
reg [WIDTH-1:0] sync_ff;

// Both stages freeze with the clock enable so no half-moved sample leaks.
always @(posedge clock)
begin
  if (!nrst)
  begin
    meta_ff <= {WIDTH{1'b0}};
    sync_ff <= {WIDTH{1'b0}};
  end
  else if (ce)
  begin
    meta_ff <= async_in;
    sync_ff <= meta_ff;
  end
end

assign sync_out = sync_ff;

endmodule // acc_sync

// ---- verification/acc_chk.sv ----
// Checker of the comparator control block, watching its ports only.
// Assumes one clock domain, ce held high and an APB master that keeps the bus rules.
`timescale 1ns/100ps
`include "acc_map.vh"
module acc_chk
(
  input wire clock,
  input wire nrst,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire raw_above,
  input wire positive_input_select,
  input wire negative_input_select,
  input wire reference_enable,
  input wire [3:0] reference_level,
  input wire comparator_power_down,
  input wire comparator_out_pin,
  input wire comparator_out_pin_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst || !ce);
  // A completed write to the control register.
  wire wr_ctrl = psel && penable && pready && pwrite && paddr == `ACC_OFS_CTRL;
  sel_write_a: assert property (wr_ctrl |=>
    positive_input_select == $past(pwdata[7]) && negative_input_select == $past(pwdata[6]))
    else $error("input selects do not follow control write");
  lvl_write_a: assert property (wr_ctrl |=> reference_level == $past(pwdata[5:2]))
    else $error("reference level does not follow control write");
  ref_gate_a: assert property (
    reference_enable == $past(negative_input_select && reference_level <= 4'h9 && !comparator_power_down))
    else $error("reference enable wrong");
  ready_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  err_map_a: assert property (pready && !(paddr inside {`ACC_OFS_CTRL, `ACC_OFS_PWR, `ACC_OFS_STAT,
    `ACC_OFS_MASK}) |-> pslverr && prdata == 32'h0) else $error("unmapped access not refused");
  pin_gate_a: assert property (!comparator_out_pin_oe |-> !comparator_out_pin)
    else $error("pin driven while disabled");
  rise_src_a: assert property ($rose(comparator_out_pin) && $past(comparator_out_pin_oe)
    |-> $past(raw_above, 3)) else $error("result rose without raw flag");
  freeze_a: assert property (comparator_power_down && $past(comparator_power_down)
    && $stable(comparator_out_pin_oe) |-> $stable(comparator_out_pin)) else $error("result moved when down");
endmodule // acc_chk
bind acc_top acc_chk i_chk (.clock, .nrst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .raw_above, .positive_input_select, .negative_input_select, .reference_enable, .reference_level,
  .comparator_power_down, .comparator_out_pin, .comparator_out_pin_oe);

// ---- verification/acc_analog.sv ----
// Behavioural analog front end: input muxes, reference ladder and hysteresis.
// Assumes millivolt levels from the bench; the design's positive input select and reference enable steer it.
`timescale 1ns/100ps
module acc_analog
#(
  parameter int HYST = 20
)
(
  input wire logic [11:0] pin_p_mv,
  input wire logic [11:0] pin_n_mv,
  input wire logic [11:0] temp_mv,
  input wire logic positive_input_select,
  input wire logic reference_enable,
  input wire logic [3:0] reference_level,
  output logic raw_above,
  output logic raw_below
);
  int vp;
  int vn;
  always_comb
  begin
    vp = positive_input_select ? temp_mv : pin_p_mv;
    vn = reference_enable ? 200 * reference_level : pin_n_mv;
    raw_above = vp > vn + HYST;
    raw_below = vn > vp + HYST;
  end
endmodule // acc_analog

// ---- verification/analog_comparator_control_tb.sv ----
// Self-checking bench: APB registers, random analog levels, masking and power-down.
// Assumes the analog model turns the bench's millivolt levels into the raw flags.
`timescale 1ns/100ps
`include "acc_map.vh"
module analog_comparator_control_tb;
  localparam int HYST = 20;
  logic clock = 1'h0;
  logic nrst = 1'h0;
  logic ce = 1'h1;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [11:0] pin_p_mv = 12'h0;
  logic [11:0] pin_n_mv = 12'h0;
  logic [11:0] temp_mv = 12'h0;
  wire [31:0] prdata;
  wire pready, pslverr, raw_above, raw_below, positive_input_select, negative_input_select;
  wire reference_enable, comparator_power_down, comparator_out_pin, comparator_out_pin_oe, interrupt_request;
  wire [3:0] reference_level;
  logic [31:0] rd;
  logic [7:0] cfg;
  logic [2:0] st;
  logic er, res, nres;
  int seed = 61;
  int n_errors = 0;
  int compares = 0;
  int cyc = 0;
  acc_top i_dut (.clock, .nrst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .raw_above, .raw_below, .positive_input_select, .negative_input_select, .reference_enable,
    .reference_level, .comparator_power_down, .comparator_out_pin, .comparator_out_pin_oe, .interrupt_request);
  acc_analog #(.HYST(HYST)) i_ana (.pin_p_mv, .pin_n_mv, .temp_mv, .positive_input_select, .reference_enable,
    .reference_level, .raw_above, .raw_below);
  // Clock and a hang limit well above the expected run.
  always #2.5 clock = ~clock;
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_errors++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    compares++;
    if (s !== x)
    begin
      n_errors++;
      $display("mismatch t=%0t got %h exp %h", $time, s, x);
    end
  endtask
  // One APB transfer; the request holds until pready is seen at an edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    @(posedge clock);
    // No cycle count is assumed here; only the bench's hang limit ends a wait.
    while (pready !== 1'h1)
      @(posedge clock);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clock);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] x);
    apb(1'h0, a, 32'h0);
    chk(rd, x);
  endtask
  // Waits out the synchroniser, then folds the predicted result into the event bits.
  task automatic upd(input logic down);
    int vp;
    int vn;
    repeat (6) @(posedge clock);
    vp = cfg[7] ? temp_mv : pin_p_mv;
    vn = cfg[6] ? 200 * cfg[5:2] : pin_n_mv;
    nres = down ? res : vp > vn + HYST ? 1'h1 : vn > vp + HYST ? 1'h0 : res;
    if (nres !== res)
      st = st | {~nres, nres, 1'h1};
    res = nres;
  endtask
  initial
  begin
    res = 1'h0;
    st = 3'h0;
    cfg = `ACC_CTRL_RST;
    repeat (5) @(posedge clock);
    nrst <= 1'h1;
    rchk(`ACC_OFS_CTRL, 32'h14);
    rchk(`ACC_OFS_STAT, 32'h0);
    rchk(12'hF8C, 32'h0);
    chk(er, 1'h1);
    // Random control words, reserved levels included, read back.
    repeat (8)
    begin
      rd = $random(seed);
      cfg = rd[7:0];
      apb(1'h1, `ACC_OFS_CTRL, rd);
      rchk(`ACC_OFS_CTRL, {24'h0, cfg});
      chk({positive_input_select, negative_input_select, reference_level}, cfg[7:2]);
      chk(reference_enable, cfg[6] && cfg[5:2] <= 4'h9);
    end
    apb(1'h1, `ACC_OFS_CTRL, 32'h0);
    apb(1'h1, `ACC_OFS_MASK, 32'h7);
    apb(1'h1, `ACC_OFS_PWR, 32'h2);
    cfg = 8'h0;
    rchk(`ACC_OFS_STAT, 32'h0);
    repeat (24)
    begin
      pin_p_mv <= $random(seed) & 12'h7FF;
      pin_n_mv <= $random(seed) & 12'h7FF;
      temp_mv <= $random(seed) & 12'h7FF;
      upd(1'h0);
      chk({comparator_out_pin_oe, comparator_out_pin}, {1'h1, res});
      rd = $random(seed);
      cfg = rd[0] ? {rd[7], cfg[6], 4'(rd[11:8] % 10), 2'h0} : cfg ^ 8'h40;
      apb(1'h1, `ACC_OFS_CTRL, {24'h0, cfg});
      upd(1'h0);
      chk(comparator_out_pin, res);
      chk(interrupt_request, st != 3'h0);
      rchk(`ACC_OFS_STAT, {24'h0, res, 4'h0, st});
      st = 3'h0;
    end
    // Masked event stays quiet until unmasked, then a read clears it.
    // mask, reconfigure, settle
    apb(1'h1, `ACC_OFS_MASK, 32'h0);
    cfg = 8'h0;
    apb(1'h1, `ACC_OFS_CTRL, 32'h0);
    pin_p_mv <= res ? 12'h0 : 12'h7D0;
    pin_n_mv <= res ? 12'h7D0 : 12'h0;
    upd(1'h0);
    chk(interrupt_request, 1'h0);
    apb(1'h1, `ACC_OFS_MASK, 32'h1);
    repeat (2) @(posedge clock);
    chk(interrupt_request, 1'h1);
    rchk(`ACC_OFS_STAT, {24'h0, res, 4'h0, st});
    st = 3'h0;
    repeat (2) @(posedge clock);
    chk(interrupt_request, 1'h0);
    // Powered down: result frozen and no events, then it follows again.
    apb(1'h1, `ACC_OFS_PWR, 32'h3);
    pin_p_mv <= pin_n_mv;
    pin_n_mv <= pin_p_mv;
    upd(1'h1);
    chk({comparator_power_down, comparator_out_pin}, {1'h1, res});
    rchk(`ACC_OFS_STAT, {24'h0, res, 7'h0});
    apb(1'h1, `ACC_OFS_PWR, 32'h2);
    upd(1'h0);
    chk(comparator_out_pin, res);
    // Clock enable low freezes the result although the inputs swap.
    ce <= 1'h0;
    pin_p_mv <= pin_n_mv;
    pin_n_mv <= pin_p_mv;
    repeat (6) @(posedge clock);
    chk(comparator_out_pin, res);
    ce <= 1'h1;
    upd(1'h0);
    chk(comparator_out_pin, res);
    apb(1'h1, `ACC_OFS_PWR, 32'h0);
    // The pin and its enable follow the power register one edge after the write.
    @(posedge clock);
    chk({comparator_out_pin_oe, comparator_out_pin}, 2'h0);
    print_verdict();
  end
endmodule // analog_comparator_control_tb
